/* File: inc/fsps_cfg.svh */
// constants of the flash self-program sequencer
`ifndef FSPS_CFG_SVH
`define FSPS_CFG_SVH
// ----------------------------------------
// control register layout
// ----------------------------------------
`define FSPS_CON_START   15
`define FSPS_CON_EN      14
`define FSPS_CON_ERR     13
`define FSPS_CON_ERASE   6
`define FSPS_OP_W        4
`define FSPS_OP_ROW      4'h1
`define FSPS_OP_PAGE     4'h2
`define FSPS_OP_WORD     4'h3
`define FSPS_KEY_FIRST   8'h55
`define FSPS_KEY_SECOND  8'haa
// ----------------------------------------
// array geometry, program address units
// ----------------------------------------
`define FSPS_BUF_WORDS   64
`define FSPS_ROW_LSB     7
`define FSPS_PAGE_LSB    10
// ----------------------------------------
// timing
// ----------------------------------------
`define FSPS_RC_KHZ      7370
`define FSPS_PCLK_KHZ    250000
`define FSPS_ROW_RC      11064
`define FSPS_WORD_RC     1000
`define FSPS_PAGE_RC     10000
// ----------------------------------------
// host apb map
// ----------------------------------------
`define FSPS_A_CMD       12'h000
`define FSPS_A_DATA      12'h004
`define FSPS_A_STAT      12'h008
`endif

/* File: inc/fsps_pkg.sv */
// types shared by both ends of the sequencer
package fsps_pkg;
   typedef enum logic [3:0] {
      FSPS_K_TWL,
      FSPS_K_TWH,
      FSPS_K_TRL,
      FSPS_K_TRH,
      FSPS_K_CON_WR,
      FSPS_K_CON_RD,
      FSPS_K_KEY_WR,
      FSPS_K_PAG_WR,
      FSPS_K_PAG_RD
   } fsps_kind_t;
   typedef enum logic [1:0] {
      FSPS_A_ROW,
      FSPS_A_WORD,
      FSPS_A_PAGE
   } fsps_aop_t;
endpackage

/* File: inc/fsps_if.sv */
// cpu to sequencer access channel
`timescale 1ns/1ps
interface fsps_if;
   import fsps_pkg::*;
   logic        req;
   fsps_kind_t  kind;
   logic        byte_mode;
   logic        byte_sel;
   logic [15:0] eff_addr;
   logic [15:0] wdata;
   logic        ack;
   logic [15:0] rdata;
   logic        stall;
   modport dev (input req, kind, byte_mode, byte_sel, eff_addr, wdata,
                output ack, rdata, stall);
   modport cpu (output req, kind, byte_mode, byte_sel, eff_addr, wdata,
                input ack, rdata, stall);
endinterface

/* File: logic/fsps_timer.sv */
// self-timed operation counter
`timescale 1ns/1ps
module fsps_timer
#(
   parameter int W = 24
)
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   output logic              busy,
   output logic              done
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= '0;
      end
      else if (load)
      begin
         cnt_q <= count;
      end
      else if (cnt_q != '0)
      begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done <= 1'b0;
      end
      else
      begin
         done <= (cnt_q == W'(1)) && !load;
      end
   end

   assign busy = (cnt_q != '0);
endmodule // fsps_timer

/* File: logic/fsps_device.sv */
// sequencer end: holding buffer, address, key, control, timing
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "fsps_cfg.svh"
// How it works
// - rows of 64 words; row or word program
// - page erase clears eight rows at once
// - pages and rows aligned from memory start
// - 64-word buffer loaded in aligned order
// - cpu fills buffer with 64 pairs first
// - table write touches buffer only, two cycles
// - address is table page joined to offset
// - low table access covers bits 15..0
// - high table access covers bits 23..16
// - start bit launches, hardware clears it
// - cpu stalled while operation runs
// - write-only key, 55 then aa
// - erase with code 0010 erases page
// - no erase, code 0001 programs row
// - no erase, code 0011 programs word; other codes start no array operation
// - control bits cleared only by power-on
// - cpu sets erase address by table write
// - cpu puts two nops after start
// - duration fixed in rc cycles at 7.37mhz
// - one start command per row
module fsps_device
   import fsps_pkg::*;
#(
   parameter int unsigned ROW_CYC  = int'((64'(`FSPS_ROW_RC)
      * 64'(`FSPS_PCLK_KHZ) + 64'(`FSPS_RC_KHZ) - 64'd1)
      / 64'(`FSPS_RC_KHZ)),
   parameter int unsigned WORD_CYC = int'((64'(`FSPS_WORD_RC)
      * 64'(`FSPS_PCLK_KHZ) + 64'(`FSPS_RC_KHZ) - 64'd1)
      / 64'(`FSPS_RC_KHZ)),
   parameter int unsigned PAGE_CYC = int'((64'(`FSPS_PAGE_RC)
      * 64'(`FSPS_PCLK_KHZ) + 64'(`FSPS_RC_KHZ) - 64'd1)
      / 64'(`FSPS_RC_KHZ)),
   parameter int          TW       = 24
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        sys_rst_n,
   fsps_if.dev              bus,
   output logic             arr_start,
   output fsps_aop_t        arr_op,
   output logic [23:0]      arr_addr,
   output logic [23:0]      arr_raddr,
   input  wire logic [23:0] arr_rdata,
   input  wire logic [5:0]  buf_idx,
   output logic [23:0]      buf_word,
   output logic             arr_busy
);
   localparam int BW = $clog2(`FSPS_BUF_WORDS);
   typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} fsps_key_t;

   logic [23:0]        hold_q [`FSPS_BUF_WORDS];
   logic [7:0]         page_q;
   logic [23:0]        tgt_q;
   logic               start_q, en_q, err_q, erase_q;
   logic [`FSPS_OP_W-1:0] op_q;
   fsps_key_t          key_q;
   logic               ack_q;
   logic [15:0]        rdata_q;
   logic               take, con_wr, start_req, op_ok;
   logic [23:0]        addr;
   logic [BW-1:0]      widx;
   logic [TW-1:0]      tload;
   logic               tbusy, tdone;
   logic               erase_w;
   logic [`FSPS_OP_W-1:0] op_w;

   // ----------------------------------------
   // access acceptance
   // ----------------------------------------
   assign take      = bus.req && !ack_q && !tbusy;
   assign addr      = {page_q, bus.eff_addr};
   assign widx      = bus.eff_addr[BW:1];
   assign con_wr    = take && (bus.kind == FSPS_K_CON_WR);
   assign start_req = con_wr && bus.wdata[`FSPS_CON_START];
   assign erase_w   = bus.wdata[`FSPS_CON_ERASE];
   assign op_w      = bus.wdata[`FSPS_OP_W-1:0];
   assign op_ok     = erase_w ? (op_w == `FSPS_OP_PAGE)
                              : (op_w == `FSPS_OP_ROW ||
                                 op_w == `FSPS_OP_WORD);
   assign bus.ack   = ack_q;
   assign bus.rdata = rdata_q;
   assign bus.stall = tbusy;
   assign arr_raddr = addr;
   assign arr_busy  = tbusy;
   assign buf_word  = hold_q[buf_idx];

   // each access answers one cycle after it is seen: two cycles total
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= take;
      end
   end

   // ----------------------------------------
   // holding buffer, written only by table writes
   // ----------------------------------------
   for (genvar i = 0; i < `FSPS_BUF_WORDS; i++)
   begin : g_hold
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            hold_q[i] <= '0;
         end
         else if (take && widx == BW'(i))
         begin
            if (bus.kind == FSPS_K_TWL)
            begin
               if (!bus.byte_mode)
                  hold_q[i][15:0] <= bus.wdata;
               else if (bus.byte_sel)
                  hold_q[i][15:8] <= bus.wdata[7:0];
               else
                  hold_q[i][7:0] <= bus.wdata[7:0];
            end
            // phantom upper byte is dropped
            else if (bus.kind == FSPS_K_TWH &&
                     !(bus.byte_mode && bus.byte_sel))
            begin
               hold_q[i][23:16] <= bus.wdata[7:0];
            end
         end
      end
   end

   // ----------------------------------------
   // table page and latched target address
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         page_q <= '0;
         tgt_q  <= '0;
      end
      else if (!sys_rst_n)
      begin
         page_q <= '0;
      end
      else if (take)
      begin
         if (bus.kind == FSPS_K_PAG_WR)
            page_q <= bus.wdata[7:0];
         if (bus.kind == FSPS_K_TWL || bus.kind == FSPS_K_TWH)
            tgt_q <= addr;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_q <= '0;
      end
      else if (take)
      begin
         unique case (bus.kind)
            FSPS_K_TRL:
               if (!bus.byte_mode)
                  rdata_q <= arr_rdata[15:0];
               else
                  rdata_q <= {8'h00, bus.byte_sel ? arr_rdata[15:8]
                                                  : arr_rdata[7:0]};
            FSPS_K_TRH:
               rdata_q <= {8'h00, (bus.byte_mode && bus.byte_sel)
                                  ? 8'h00 : arr_rdata[23:16]};
            FSPS_K_CON_RD:
               rdata_q <= {start_q, en_q, err_q, 6'h00, erase_q,
                           2'h0, op_q};
            FSPS_K_PAG_RD:
               rdata_q <= {8'h00, page_q};
            default:
               rdata_q <= '0;
         endcase
      end
   end

   // ----------------------------------------
   // unlock key; any other write breaks it
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         key_q <= KEY_IDLE;
      end
      else if (!sys_rst_n)
      begin
         key_q <= KEY_IDLE;
      end
      else if (take)
      begin
         if (bus.kind == FSPS_K_KEY_WR)
         begin
            if (bus.wdata[7:0] == `FSPS_KEY_FIRST)
               key_q <= KEY_HALF;
            else if (key_q == KEY_HALF &&
                     bus.wdata[7:0] == `FSPS_KEY_SECOND)
               key_q <= KEY_OPEN;
            else
               key_q <= KEY_IDLE;
         end
         else if (bus.kind != FSPS_K_TRL && bus.kind != FSPS_K_TRH &&
                  bus.kind != FSPS_K_CON_RD && bus.kind != FSPS_K_PAG_RD)
         begin
            key_q <= KEY_IDLE;
         end
      end
   end

   // ----------------------------------------
   // control register, cleared by power-on only
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_q    <= 1'b0;
         erase_q <= 1'b0;
         op_q    <= '0;
      end
      else if (con_wr)
      begin
         en_q    <= bus.wdata[`FSPS_CON_EN];
         erase_q <= erase_w;
         op_q    <= op_w;
      end
   end

   // start only with key open and enable set in the same write
   assign arr_start = start_req && key_q == KEY_OPEN &&
                      bus.wdata[`FSPS_CON_EN] && op_ok;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_q <= 1'b0;
      end
      else if (arr_start)
      begin
         start_q <= 1'b1;
      end
      else if (tdone)
      begin
         start_q <= 1'b0;
      end
   end

   // set wins over a software clear in the same write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         err_q <= 1'b0;
      end
      else if (start_req && (key_q != KEY_OPEN ||
               !bus.wdata[`FSPS_CON_EN]))
      begin
         err_q <= 1'b1;
      end
      else if (con_wr)
      begin
         err_q <= bus.wdata[`FSPS_CON_ERR];
      end
   end

   // ----------------------------------------
   // array operation and self timing
   // ----------------------------------------
   always_comb
   begin
      arr_op   = FSPS_A_WORD;
      arr_addr = tgt_q;
      tload    = TW'(WORD_CYC);
      if (erase_w)
      begin
         arr_op   = FSPS_A_PAGE;
         arr_addr = {tgt_q[23:`FSPS_PAGE_LSB], `FSPS_PAGE_LSB'(0)};
         tload    = TW'(PAGE_CYC);
      end
      else if (op_w == `FSPS_OP_ROW)
      begin
         arr_op   = FSPS_A_ROW;
         arr_addr = {tgt_q[23:`FSPS_ROW_LSB], `FSPS_ROW_LSB'(0)};
         tload    = TW'(ROW_CYC);
      end
   end

   fsps_timer #(
      .W       (TW)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (arr_start),
      .count   (tload),
      .busy    (tbusy),
      .done    (tdone)
   );

endmodule // fsps_device

/* File: logic/fsps_host.sv */
// cpu end: apb-driven issuer of table and register accesses
`timescale 1ns/1ps
`include "fsps_cfg.svh"
module fsps_host
   import fsps_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   fsps_if.cpu              bus
);
   logic        req_q, done_q, bmode_q, bsel_q;
   fsps_kind_t  kind_q;
   logic [15:0] eff_addr_q, wdata_q, rdata_q;
   logic        acc, go, hit;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   assign acc = psel && penable;
   assign go  = acc && pwrite && paddr == `FSPS_A_DATA;
   assign hit = paddr == `FSPS_A_CMD || paddr == `FSPS_A_DATA ||
                paddr == `FSPS_A_STAT;
   // the issuing write waits for the answer; stall stretches it
   assign pready  = go ? done_q : 1'b1;
   assign pslverr = acc && !hit;

   always_comb
   begin
      prdata = '0;
      if (paddr == `FSPS_A_CMD)
         prdata = {eff_addr_q, 10'h000, bsel_q, bmode_q, kind_q};
      else if (paddr == `FSPS_A_DATA)
         prdata = {16'h0000, rdata_q};
      else if (paddr == `FSPS_A_STAT)
         prdata = {30'h0, req_q, bus.stall};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         kind_q  <= FSPS_K_CON_RD;
         bmode_q <= 1'b0;
         bsel_q  <= 1'b0;
         eff_addr_q <= '0;
      end
      else if (acc && pwrite && paddr == `FSPS_A_CMD)
      begin
         kind_q  <= fsps_kind_t'(pwdata[3:0]);
         bmode_q <= pwdata[4];
         bsel_q  <= pwdata[5];
         eff_addr_q <= pwdata[31:16];
      end
   end

   // ----------------------------------------
   // request toward the sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_q   <= 1'b0;
         done_q  <= 1'b0;
         wdata_q <= '0;
         rdata_q <= '0;
      end
      else
      begin
         if (go && !req_q && !done_q)
         begin
            req_q   <= 1'b1;
            wdata_q <= pwdata[15:0];
         end
         else if (req_q && bus.ack)
         begin
            req_q   <= 1'b0;
            done_q  <= 1'b1;
            rdata_q <= bus.rdata;
         end
         else if (go && done_q)
         begin
            done_q <= 1'b0;
         end
      end
   end

   assign bus.req       = req_q;
   assign bus.kind      = kind_q;
   assign bus.byte_mode = bmode_q;
   assign bus.byte_sel  = bsel_q;
   assign bus.eff_addr  = eff_addr_q;
   assign bus.wdata     = wdata_q;
endmodule // fsps_host

/* File: verification/fsps_props.sv */
// concurrent checks on the cpu to sequencer channel
`timescale 1ns/1ps
module fsps_props
   import fsps_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        req,
   input wire fsps_kind_t  kind,
   input wire logic        ack,
   input wire logic        stall,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        arr_start,
   input wire fsps_aop_t   arr_op
);
   logic take;
   // a request is taken only when nothing is pending or running
   assign take = req & ~ack & ~stall;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ack_single: assert property (ack |=> !ack)
      else $error("ack held longer than one cycle");
   a_ack_follows: assert property (take |=> ack)
      else $error("take not answered next cycle");
   a_ack_cause: assert property (ack |-> $past(take))
      else $error("ack without a taken request");
   a_stall_blocks: assert property (stall && $past(stall) |-> !ack)
      else $error("request answered during stall");
   a_start_runs: assert property (arr_start |=> stall[*8] ##1 !stall)
      else $error("stall length wrong after start");
   a_stall_origin: assert property ($rose(stall) |-> $past(arr_start))
      else $error("stall rose without a start");
   a_start_cause: assert property (arr_start |-> take &&
      kind == FSPS_K_CON_WR && wdata[15] && wdata[14])
      else $error("start without enabled control write");
   a_start_legal: assert property (arr_start |->
      (wdata[6] && wdata[3:0] == 4'h2 && arr_op == FSPS_A_PAGE) ||
      (!wdata[6] && wdata[3:0] == 4'h1 && arr_op == FSPS_A_ROW) ||
      (!wdata[6] && wdata[3:0] == 4'h3 && arr_op == FSPS_A_WORD))
      else $error("start for wrong or unknown op code");
   a_rdata_hold: assert property (!$past(take) |-> $stable(rdata))
      else $error("read data moved without a request");
   c_page: cover property (arr_start && arr_op == FSPS_A_PAGE);
   c_high: cover property (take && kind == FSPS_K_TWH);
   c_done: cover property ($fell(stall));
endmodule // fsps_props

/* File: verification/flash_self_program_sequencer_bench.sv */
// self-checking bench for both ends of the sequencer
`timescale 1ns/1ps
`include "fsps_cfg.svh"
module flash_self_program_sequencer_bench
   import fsps_pkg::*;
;
   logic        pclk, presetn, sys_rst_n, psel, penable, pwrite, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr, arr_start, arr_busy;
   fsps_aop_t   arr_op, last_op;
   logic [23:0] arr_addr, arr_raddr, arr_rdata, buf_word, last_addr, v, m;
   logic [5:0]  buf_idx;
   logic [23:0] exp_buf [64];
   logic [7:0]  pg;
   logic [15:0] base, eff_addr;
   logic [2:0]  xo;
   int          n_fail, n_compared, n_start, s0;
   fsps_if bus_if ();
   fsps_device #(.ROW_CYC(8), .WORD_CYC(8), .PAGE_CYC(8), .TW(24))
   i_fsps_device (.pclk(pclk), .presetn(presetn), .sys_rst_n(sys_rst_n),
      .bus(bus_if.dev), .arr_start(arr_start), .arr_op(arr_op),
      .arr_addr(arr_addr), .arr_raddr(arr_raddr), .arr_rdata(arr_rdata),
      .buf_idx(buf_idx), .buf_word(buf_word), .arr_busy(arr_busy));
   fsps_host i_fsps_host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if.cpu));
   fsps_props i_fsps_props (.pclk(pclk), .presetn(presetn),
      .req(bus_if.req), .kind(bus_if.kind), .ack(bus_if.ack),
      .stall(bus_if.stall), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
      .arr_start(arr_start), .arr_op(arr_op));
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      if (arr_start === 1'b1)
      begin
         n_start <= n_start + 1;
         last_op <= arr_op;
         last_addr <= arr_addr;
      end
   end
   task chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
      n_compared++;
      if (got !== ex)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // answer taken at the edge that samples it, before its own updates
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task acc(input fsps_kind_t k, input logic [15:0] a, input logic [15:0] d,
            input logic [1:0] bs);
      apb(1'b1, `FSPS_A_CMD, {a, 10'h000, bs, k});
      apb(1'b1, `FSPS_A_DATA, {16'h0000, d});
   endtask
   task rd(input fsps_kind_t k, input logic [15:0] a, input logic [1:0] bs);
      acc(k, a, 16'h0000, bs);
      apb(1'b0, `FSPS_A_DATA, 32'h0);
      v = {8'h00, r[15:0]};
   endtask
   task go(input logic [15:0] c);
      acc(FSPS_K_KEY_WR, 16'h0000, 16'h0055, 2'b00);
      acc(FSPS_K_KEY_WR, 16'h0000, 16'h00aa, 2'b00);
      acc(FSPS_K_CON_WR, 16'h0000, c, 2'b00);
   endtask
   task settle;
      do
      begin
         @(posedge pclk);
      end
      while (bus_if.stall !== 1'b0);
   endtask
   function automatic logic [2:0] exp_op(input logic er, input logic [3:0] o);
      if (er && o == 4'h2) return {1'b1, FSPS_A_PAGE};
      if (!er && o == 4'h1) return {1'b1, FSPS_A_ROW};
      if (!er && o == 4'h3) return {1'b1, FSPS_A_WORD};
      return 3'b000;
   endfunction
   task conclude;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #200000;
      n_fail++;
      conclude;
   end
   initial
   begin
      {n_fail, n_compared, n_start} = '0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {buf_idx, arr_rdata} = '0;
      sys_rst_n = 1'b1;
      void'($urandom(32'h8d9c));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(FSPS_K_CON_RD, 16'h0000, 2'b00);
      chk("con at reset", 24'h0, v);
      pg = 8'($urandom_range(127));
      base = 16'($urandom) & 16'hff80;
      acc(FSPS_K_PAG_WR, 16'h0000, {8'h00, pg}, 2'b00);
      for (int i = 0; i < 64; i++)
      begin
         exp_buf[i] = 24'($urandom);
         eff_addr = base + 16'(2 * i);
         acc(FSPS_K_TWL, eff_addr, exp_buf[i][15:0], 2'b00);
         acc(FSPS_K_TWH, eff_addr, {8'h00, exp_buf[i][23:16]}, 2'b00);
      end
      acc(FSPS_K_TWL, base, 16'h00c3, 2'b11);
      exp_buf[0][15:8] = 8'hc3;
      chk("raddr", {pg, base}, arr_raddr);
      for (int i = 0; i < 64; i++)
      begin
         buf_idx <= 6'(i);
         @(negedge pclk);
         chk("buffer", exp_buf[i], buf_word);
         @(posedge pclk);
      end
      $display("test buffer load done");
      arr_rdata <= 24'($urandom);
      rd(FSPS_K_TRL, base, 2'b00);
      chk("read low", {8'h00, arr_rdata[15:0]}, v);
      rd(FSPS_K_TRL, base, 2'b11);
      chk("read low hi byte", {16'h0, arr_rdata[15:8]}, v);
      rd(FSPS_K_TRH, base, 2'b00);
      chk("read high", {16'h0, arr_rdata[23:16]}, v);
      rd(FSPS_K_TRH, base, 2'b11);
      chk("read phantom", 24'h0, v);
      $display("test table read done");
      for (int c = 0; c < 32; c++)
      begin
         xo = exp_op(c[4], c[3:0]);
         s0 = n_start;
         acc(FSPS_K_TWL, base + 16'h0046, exp_buf[35][15:0], 2'b00);
         go({9'h180, c[4], 2'b00, c[3:0]});
         if (xo[2])
         begin
            chk("busy", 24'h1, {23'h0, arr_busy});
            repeat (2) @(posedge pclk);
            apb(1'b0, `FSPS_A_STAT, 32'h0);
            chk("stall", 24'h1, {23'h0, r[0]});
            settle;
            chk("op", {21'h0, xo}, {21'h0, 1'b1, last_op});
            m = (xo[1:0] == FSPS_A_PAGE) ? 24'hfffc00 :
                (xo[1:0] == FSPS_A_ROW) ? 24'hffff80 : 24'hffffff;
            chk("addr", {pg, base + 16'h0046} & m, last_addr);
            rd(FSPS_K_CON_RD, 16'h0000, 2'b00);
            chk("con done", {8'h00, 9'h080, c[4], 2'b00, c[3:0]}, v);
         end
         chk("starts", 24'(s0 + int'(xo[2])), 24'(n_start));
      end
      $display("test op codes done");
      s0 = n_start;
      go(16'h8001);
      rd(FSPS_K_CON_RD, 16'h0000, 2'b00);
      chk("con disabled", 24'h002001, v);
      acc(FSPS_K_CON_WR, 16'h0000, 16'h4001, 2'b00);
      acc(FSPS_K_KEY_WR, 16'h0000, 16'h0055, 2'b00);
      acc(FSPS_K_TWL, base, exp_buf[0][15:0], 2'b00);
      acc(FSPS_K_KEY_WR, 16'h0000, 16'h00aa, 2'b00);
      acc(FSPS_K_CON_WR, 16'h0000, 16'hc001, 2'b00);
      rd(FSPS_K_CON_RD, 16'h0000, 2'b00);
      chk("con broken key", 24'h006001, v);
      chk("no start", 24'(s0), 24'(n_start));
      sys_rst_n <= 1'b0;
      @(posedge pclk);
      sys_rst_n <= 1'b1;
      @(posedge pclk);
      rd(FSPS_K_CON_RD, 16'h0000, 2'b00);
      chk("con sys reset", 24'h006001, v);
      apb(1'b0, 12'hffc, 32'h0);
      chk("unmapped", 24'h1, {23'h0, e});
      $display("test errors done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(FSPS_K_CON_RD, 16'h0000, 2'b00);
      chk("con power reset", 24'h0, v);
      $display("test resets done");
      conclude;
   end
endmodule // flash_self_program_sequencer_bench
